// >>> shared/sef_regs.svh
// Register map, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design files
`ifndef SEF_REGS_SVH
`define SEF_REGS_SVH

// Register bank and offsets
`define SEF_BANK_CTL 4'h6
`define SEF_OFF_BUF 8'h10
`define SEF_OFF_CTL1 8'h11
`define SEF_OFF_STAT 8'h12
`define SEF_OFF_IRQ 8'h13
`define SEF_OFF_MASK 8'h14

// Control register layout and reset value
`define SEF_CTL1_RST 8'h00
`define SEF_WRITE_COLLISION_FLAG_BIT 7
`define SEF_OV_BIT 6
`define SEF_EN_BIT 5
`define SEF_CKP_BIT 4

// Mode field codes
`define SEF_MODE_SPI_SS 4'h4
`define SEF_MODE_SPI_NOSS 4'h5
`define SEF_MODE_I2C_S7 4'h6
`define SEF_MODE_I2C_S10 4'h7
`define SEF_MODE_I2C_M 4'h8

// Interrupt status bit positions
`define SEF_IRQ_DONE 0
`define SEF_IRQ_WRITE_COLLISION_FLAG 1
`define SEF_IRQ_OV 2
`define SEF_IRQ_W 3

// Bits per byte
`define SEF_DATA_BITS 4'h8

// Master shift clock half period
`define SEF_CLK_NS 100
`define SEF_SPI_HALF_NS 400
`define SEF_SPI_HALF_CYC \
    ((`SEF_SPI_HALF_NS + `SEF_CLK_NS - 1) / `SEF_CLK_NS)

`endif

// >>> shared/sef_pkg.sv
// Types shared by the serial error flag block
// Assumes nothing beyond the compile order
package sef_pkg;

    // Phase of the byte shifter
    typedef enum logic [1:0] {
        SEF_IDLE,
        SEF_DATA,
        SEF_TAIL
    } sef_phase_e;

    // State of the top module, apart from its pin synchronisers and flag registers
    typedef struct packed {
        sef_phase_e phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] rbuf;
        logic rx_full;
        logic tx_full;
        logic en;
        logic clock_polarity_bit;
        logic [3:0] mode;
        logic gen_clk;
        logic [2:0] divcnt;
        logic sclk_d;
        logic sdo;
        logic sda_oe;
        logic [7:0] rdata;
        logic [2:0] mask;
        logic irq;
        logic sck;
        logic sck_oe;
    } sef_state_s;

endpackage

// >>> rtl/sef_sync.sv
// Two flip-flop synchroniser for pin inputs
// Assumes inputs asynchronous to the core clock
`timescale 1ns/1ns
module sef_sync import sef_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sef_sync_s;

    sef_sync_s s;
    sef_sync_s next_s;

    // Meta stage feeds only the second stage
    always_comb begin
        next_s = s;
        next_s.meta = d_i;
        next_s.q = s.meta;
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else if (en_i) begin
            s <= next_s;
        end
    end

    assign q_o = s.q;
endmodule

// >>> rtl/sef_flag.sv
// Sticky flags written by software and set by hardware
// Assumes set pulses and writes on the same clock
`timescale 1ns/1ns
module sef_flag import sef_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [W-1:0] set_i,
    input wire logic wr_i,
    input wire logic [W-1:0] wval_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] q;
    } sef_flag_s;

    sef_flag_s s;
    sef_flag_s next_s;

    // Hardware set wins over a software write
    always_comb begin
        next_s = s;
        next_s.q = set_i | (wr_i ? wval_i : s.q);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else if (en_i) begin
            s <= next_s;
        end
    end

    assign q_o = s.q;
endmodule

// >>> rtl/sef_top.sv
// Synchronous serial port byte shifter with error and status flags
// Assumes a core-clock register port and asynchronous link pins
// Operation
// RULE1: In I2C transmit the buffer-full flag reads 1 while data bits shift.
// RULE2: After the eighth I2C data bit the buffer-full flag reads 0.
// RULE3: Control bit 7 is write collision, bit 6 overflow, all RW, reset 0.
// RULE4: The control register sits at offset 11h of bank 6.
// RULE5: I2C master writes to the buffer on a busy bus set collision.
// RULE6: Slave writes to the buffer during a transfer set collision.
// RULE7: An SPI byte arriving on an unread buffer sets overflow, is dropped.
// RULE8: SPI overflow can only set in slave operation.
// RULE9: SPI master operation never sets overflow.
// RULE10: Software reads the buffer after every byte in SPI slave mode.
// RULE11: An I2C byte arriving on an unread buffer sets overflow.
// RULE12: The mode field selects SPI master, SPI slave, I2C slave or master.
// RULE13: Writing 0 clears an error flag; a same-cycle error still sets it.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "sef_regs.svh"
module sef_top import sef_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [3:0] bank_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic sdi_i,
    output logic sck_o,
    output logic sck_oe_o,
    output logic sdo_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic i2c_bus_idle_i,
    input wire logic i2c_tx_i
);
    localparam logic [2:0] HALF_CYC = 3'(`SEF_SPI_HALF_CYC - 1);

    sef_state_s s;
    sef_state_s next_s;
    logic [4:0] pin_s;
    logic sck_s, ss_n_s, sdi_s, scl_s, sda_s;
    logic [1:0] err_q;
    logic [2:0] irq_q;
    logic [2:0] irq_set;
    logic spi_m, spi_s, i2c_s, i2c_m, i2c, act;
    logic sel, wr_buf, rd_buf, wr_ctl, wr_irq;
    logic lvl, lead, trail, din, busy, ss_block;
    logic write_collision_flag_ev, ov_ev, complete, load;
    logic [7:0] dbyte;
    logic [7:0] ctl_val;
    logic bf;
    logic new_lvl, cfg_chg;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and flag storage

    // Link pins pass two flops
    sef_sync #(.W(5)) u_sync (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i),
        .d_i({sda_i, scl_i, sdi_i, ss_n_i, sck_i}),
        .q_o(pin_s)
    );
    assign {sda_s, scl_s, sdi_s, ss_n_s, sck_s} = pin_s;

    // Collision and overflow flags in the control register
    sef_flag #(.W(2)) u_err (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i),
        .set_i({write_collision_flag_ev, ov_ev}), // RULE13
        .wr_i(wr_ctl),
        .wval_i(wdata_i[`SEF_WRITE_COLLISION_FLAG_BIT:`SEF_OV_BIT]), // RULE13
        .q_o(err_q)
    );

    // Interrupt status, write one to clear
    assign irq_set = {ov_ev, write_collision_flag_ev, complete};
    sef_flag #(.W(`SEF_IRQ_W)) u_irq (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i),
        .set_i(irq_set),
        .wr_i(wr_irq),
        .wval_i(irq_q & ~wdata_i[2:0]),
        .q_o(irq_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Decode

    // Mode field decode
    always_comb begin
        spi_m = (s.mode[3:2] == 2'b00); // RULE12
        spi_s = (s.mode == `SEF_MODE_SPI_SS) ||
                (s.mode == `SEF_MODE_SPI_NOSS); // RULE12
        i2c_s = (s.mode == `SEF_MODE_I2C_S7) ||
                (s.mode == `SEF_MODE_I2C_S10); // RULE12
        i2c_m = (s.mode == `SEF_MODE_I2C_M); // RULE12
        i2c = i2c_s | i2c_m;
        act = s.en & (spi_m | spi_s | i2c);
    end

    // Register strobes
    assign sel = (bank_i == `SEF_BANK_CTL);
    assign wr_buf = wr_i & sel & (addr_i == `SEF_OFF_BUF);
    assign rd_buf = rd_i & sel & (addr_i == `SEF_OFF_BUF);
    assign wr_ctl = wr_i & sel & (addr_i == `SEF_OFF_CTL1); // RULE4
    assign wr_irq = wr_i & sel & (addr_i == `SEF_OFF_IRQ);

    // Shift clock level and its edges
    always_comb begin
        if (i2c) begin
            lvl = scl_s;
        end else if (spi_m) begin
            lvl = s.gen_clk;
        end else begin
            lvl = sck_s ^ s.clock_polarity_bit;
        end
        lead = lvl & ~s.sclk_d;
        trail = ~lvl & s.sclk_d;
        din = i2c ? sda_s : sdi_s;
        dbyte = {s.shreg[6:0], din};
        busy = (s.phase != SEF_IDLE);
        ss_block = (s.mode == `SEF_MODE_SPI_SS) & ss_n_s;
    end

    // Clock level under a newly written setup, so no false edge follows
    always_comb begin
        cfg_chg = wr_ctl & (wdata_i[5:0] != {s.en, s.clock_polarity_bit, s.mode});
        if (wdata_i[3:1] == 3'h3 || wdata_i[3:0] == `SEF_MODE_I2C_M) begin
            new_lvl = scl_s;
        end else if (wdata_i[3:2] == 2'h0) begin
            new_lvl = 1'b0;
        end else begin
            new_lvl = sck_s ^ wdata_i[`SEF_CKP_BIT];
        end
    end

    // Events of this cycle
    always_comb begin
        write_collision_flag_ev = wr_buf & act & (busy | (i2c_m & ~i2c_bus_idle_i)); // RULE5
        load = wr_buf & act & ~write_collision_flag_ev; // RULE6
        complete = act & lead & ~ss_block & (s.phase == SEF_DATA) &
                   (s.bitcnt == `SEF_DATA_BITS - 4'h1);
        ov_ev = complete & s.rx_full & // RULE7
                (spi_s | (i2c & ~i2c_tx_i)); // RULE8 RULE11
    end

    // Buffer full as seen by software
    assign bf = (i2c & i2c_tx_i) ? s.tx_full : s.rx_full;
    assign ctl_val = {err_q, s.en, s.clock_polarity_bit, s.mode}; // RULE3

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        next_s.sclk_d = lvl;
        // Control and mask writes
        if (wr_ctl) begin
            next_s.en = wdata_i[`SEF_EN_BIT]; // RULE3
            next_s.clock_polarity_bit = wdata_i[`SEF_CKP_BIT];
            next_s.mode = wdata_i[3:0];
        end
        if (wr_i & sel & (addr_i == `SEF_OFF_MASK)) begin
            next_s.mask = wdata_i[2:0];
        end
        // Buffer read frees it; a byte landing in the same cycle still finds it full
        if (rd_buf) begin
            next_s.rx_full = 1'b0;
        end
        // Accepted buffer write starts a byte
        if (load) begin
            next_s.shreg = wdata_i;
            next_s.bitcnt = 4'h0;
            next_s.phase = SEF_DATA;
            next_s.divcnt = 3'h0;
            next_s.sdo = wdata_i[7];
            next_s.tx_full = i2c & i2c_tx_i; // RULE1
            next_s.sda_oe = i2c & i2c_tx_i & ~wdata_i[7];
        end
        // Master shift clock divider
        if (act & spi_m & busy) begin
            if (s.divcnt == HALF_CYC) begin
                next_s.divcnt = 3'h0;
                next_s.gen_clk = ~s.gen_clk;
            end else begin
                next_s.divcnt = s.divcnt + 3'h1;
            end
        end
        // Sample on leading edge
        if (act & lead & ~ss_block & ~load) begin
            unique case (s.phase)
                SEF_IDLE: begin
                    if (!spi_m) begin
                        next_s.shreg = dbyte;
                        next_s.bitcnt = 4'h1;
                        next_s.phase = SEF_DATA;
                    end
                end
                SEF_DATA: begin
                    next_s.shreg = dbyte;
                    next_s.bitcnt = s.bitcnt + 4'h1;
                    if (complete) begin
                        next_s.bitcnt = 4'h0;
                        next_s.phase = spi_s ? SEF_IDLE : SEF_TAIL;
                        next_s.tx_full = 1'b0; // RULE2
                    end
                end
                SEF_TAIL: begin
                    if (i2c) begin
                        next_s.phase = SEF_IDLE;
                    end
                end
            endcase
        end
        // Drive next bit on trailing edge
        if (act & trail & ~ss_block & ~load) begin
            next_s.sdo = s.shreg[7];
            next_s.sda_oe = i2c & i2c_tx_i & ~s.shreg[7] &
                            (s.phase == SEF_DATA);
            if (spi_m & (s.phase == SEF_TAIL)) begin
                next_s.phase = SEF_IDLE;
            end
        end
        // Received byte goes to the buffer unless it is still unread; SPI master overwrites it
        if (complete & ~(i2c & i2c_tx_i)) begin
            if (!s.rx_full || spi_m) begin // RULE7 RULE9
                next_s.rbuf = dbyte;
                next_s.rx_full = 1'b1;
            end
        end
        // Disabled port, deselected slave or new setup drops the byte
        if (!act || ss_block || cfg_chg) begin
            next_s.phase = SEF_IDLE;
            next_s.bitcnt = 4'h0;
            next_s.gen_clk = 1'b0;
            next_s.divcnt = 3'h0;
            next_s.tx_full = 1'b0;
            next_s.sda_oe = 1'b0;
        end
        // Edge detector restarts from the new setup's clock level
        if (cfg_chg) begin
            next_s.sclk_d = new_lvl;
        end
        // Read data stands one cycle
        next_s.rdata = 8'h00;
        if (rd_i & sel) begin
            unique case (addr_i)
                `SEF_OFF_BUF: next_s.rdata = s.rbuf;
                `SEF_OFF_CTL1: next_s.rdata = ctl_val; // RULE4
                `SEF_OFF_STAT: next_s.rdata = {6'h00, busy, bf};
                `SEF_OFF_IRQ: next_s.rdata = {5'h00, irq_q};
                `SEF_OFF_MASK: next_s.rdata = {5'h00, s.mask};
                default: next_s.rdata = 8'h00;
            endcase
        end
        next_s.irq = |(irq_q & s.mask);
        // Clock pin and its enable follow the new state
        next_s.sck = next_s.gen_clk ^ next_s.clock_polarity_bit;
        next_s.sck_oe = next_s.en & (next_s.mode[3:2] == 2'h0);
    end

    // State register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_o = s.rdata;
    assign irq_o = s.irq;
    assign sck_o = s.sck;
    assign sck_oe_o = s.sck_oe;
    assign sdo_o = s.sdo;
    // Open drain pulls low only
    assign sda_o = 1'b0;
    assign sda_oe_o = s.sda_oe;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_bf_during_tx: assert property ( // RULE1
        clk_en_i && load && i2c && i2c_tx_i |=> s.tx_full && busy)
        else $error("buffer full not set on i2c transmit");

    a_bf_after_data: assert property ( // RULE2
        clk_en_i && complete && i2c && i2c_tx_i
        |=> !s.tx_full && s.phase == SEF_TAIL)
        else $error("buffer full not cleared after data bits");

    a_ctl_write_back: assert property ( // RULE3
        clk_en_i && wr_ctl && !write_collision_flag_ev && !ov_ev
        |=> ctl_val == $past(wdata_i))
        else $error("control register write lost");

    a_ctl_read_addr: assert property ( // RULE4
        clk_en_i && rd_i && sel && addr_i == `SEF_OFF_CTL1
        |=> rdata_o == $past(ctl_val))
        else $error("control register read wrong");

    a_write_collision_flag_i2c_master: assert property ( // RULE5
        clk_en_i && wr_buf && act && i2c_m && !i2c_bus_idle_i
        |=> err_q[1])
        else $error("collision on busy i2c bus missed");

    a_write_collision_flag_slave_busy: assert property ( // RULE6
        clk_en_i && wr_buf && act && (spi_s || i2c_s) && busy
        |=> err_q[1] && s.shreg != $past(wdata_i) || err_q[1])
        else $error("slave collision missed");

    a_ov_spi_keep: assert property ( // RULE7
        clk_en_i && complete && spi_s && s.rx_full && !rd_buf
        |=> err_q[0] && s.rbuf == $past(s.rbuf))
        else $error("spi overflow missed or buffer overwritten");

    a_ov_slave_only: assert property ( // RULE8
        clk_en_i && !wr_ctl && !err_q[0] ##1 err_q[0]
        |-> $past(spi_s) || $past(i2c))
        else $error("overflow raised outside slave");

    a_ov_never_master: assert property ( // RULE9
        clk_en_i && spi_m && !wr_ctl && !err_q[0] |=> !err_q[0])
        else $error("overflow set in spi master");

    a_ov_i2c_rx: assert property ( // RULE11
        clk_en_i && complete && i2c && !i2c_tx_i && s.rx_full
        && !rd_buf |=> err_q[0])
        else $error("i2c overflow missed");

    a_flag_clear: assert property ( // RULE13
        clk_en_i && wr_ctl && !wdata_i[`SEF_WRITE_COLLISION_FLAG_BIT] && !write_collision_flag_ev
        |=> !err_q[1])
        else $error("collision flag not cleared by write");

    c_spi_overflow: cover property (clk_en_i && ov_ev && spi_s);
    c_i2c_collision: cover property (clk_en_i && write_collision_flag_ev && i2c_m);
    c_i2c_tx_done: cover property (clk_en_i && complete && i2c_tx_i);
    c_spi_master_byte: cover property (clk_en_i && complete && spi_m);
endmodule

// >>> testbench/sef_peer.sv
// Behavioural far-end party: SPI master and I2C bus peer
// Assumes the bench calls one task at a time; 800 ns link clock
`timescale 1ns/1ns
module sef_peer (
    output logic sck_o,
    output logic ss_n_o,
    output logic sdi_o,
    output logic scl_o,
    output logic sda_o
);
    ////////////////////////////////////////
    // Idle levels: SPI clock low, I2C lines pulled up
    initial begin
        sck_o = 1'b0;
        ss_n_o = 1'b1;
        sdi_o = 1'b0;
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // One SPI byte, MSB first, data set before each leading edge
    task automatic spi_byte(input logic [7:0] d);
        integer i;
        #37;
        ss_n_o = 1'b0;
        for (i = 7; i >= 0; i--) begin
            sdi_o = d[i];
            #400 sck_o = 1'b1;
            #400 sck_o = 1'b0;
        end
        // Released data line shows the inverse of the last bit
        sdi_o = ~d[0];
        ss_n_o = 1'b1;
    endtask

    // Holds SCL low, then n pulses; bits past eight are released
    task automatic i2c_clk(input logic [7:0] d, input int n);
        int k;
        scl_o = 1'b0;
        #400;
        for (k = 0; k < n; k++) begin
            sda_o = (k < 8) ? d[7-k] : 1'b1;
            #400 scl_o = 1'b1;
            #400 scl_o = 1'b0;
        end
        sda_o = 1'b1;
    endtask

    // Lets SCL return to its pulled-up level
    task automatic i2c_idle();
        #400 scl_o = 1'b1;
    endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench: register port tasks and link traffic tests
// Assumes the peer model drives all link pins with its own timing
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] bank = 4'h6;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic bus_idle = 1'b0;
    logic tx = 1'b0;
    logic [7:0] rdata;
    logic irq, sck_o, sck_oe, sdo, sda_o, sda_oe;
    logic p_sck, p_ss_n, p_sdi, p_scl, p_sda;
    logic sda_line;
    logic [7:0] r;
    logic [7:0] mo = 8'h00;
    logic [7:0] so = 8'h00;
    int bad_count = 0;
    int samples_checked = 0;
    int m;

    // Open-drain SDA: low if either party pulls it
    assign sda_line = p_sda & (sda_oe ? sda_o : 1'b1);

    // Far-end view of the bits the block shifts out
    always @(posedge sck_o) mo <= {mo[6:0], sdo};
    always @(posedge p_scl) so <= {so[6:0], sda_line};

    sef_top sef_top_i (
        .core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
        .bank_i(bank), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .sck_i(p_sck),
        .ss_n_i(p_ss_n), .sdi_i(p_sdi), .sck_o(sck_o), .sck_oe_o(sck_oe),
        .sdo_o(sdo), .scl_i(p_scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .i2c_bus_idle_i(bus_idle), .i2c_tx_i(tx)
    );

    sef_peer sef_peer_i (
        .sck_o(p_sck), .ss_n_o(p_ss_n), .sdi_o(p_sdi),
        .scl_o(p_scl), .sda_o(p_sda)
    );

    // 10 MHz core clock
    initial begin
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe; data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Read, mask and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] k,
                          input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        chk(v & k, e);
    endtask

    // Polls the busy bit under a bound
    task automatic wait_idle();
        logic [7:0] v;
        int n;
        for (n = 0; n < 300; n++) begin
            rd_reg(8'h12, v);
            if (v[1] === 1'b0) return;
        end
        bad_count++;
        finish_test();
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("checks=%0d bad=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset value, read-write bits, decoding
        rd_chk(8'h11, 8'hff, 8'h00);
        wr_reg(8'h11, 8'hcf);
        rd_chk(8'h11, 8'hff, 8'hcf);
        wr_reg(8'h11, 8'h00);
        rd_chk(8'h11, 8'hff, 8'h00);
        rd_chk(8'h1f, 8'hff, 8'h00);
        @(posedge clk);
        bank <= 4'h5;
        wr_reg(8'h11, 8'hff);
        bank <= 4'h6;
        rd_chk(8'h11, 8'hff, 8'h00);
        $display("test regs done");
        // Every mode code; only SPI master drives the clock pin
        for (m = 0; m < 9; m++) begin
            wr_reg(8'h11, {4'h2, m[3:0]});
            @(posedge clk);
            @(negedge clk);
            chk({7'h0, sck_oe}, {7'h0, m < 4});
        end
        $display("test modes done");
        // SPI master, two unread bytes give no overflow
        wr_reg(8'h11, 8'h20);
        wr_reg(8'h10, 8'h3c);
        wait_idle();
        chk(mo, 8'h3c);
        wr_reg(8'h10, 8'hc3);
        wait_idle();
        chk(mo, 8'hc3);
        rd_chk(8'h11, 8'hff, 8'h20);
        rd_chk(8'h13, 8'h01, 8'h01);
        rd_reg(8'h10, r);
        wr_reg(8'h13, 8'h07);
        $display("test spi master done");
        // SPI slave receive, overflow, mask and interrupt
        wr_reg(8'h11, 8'h25);
        sef_peer_i.spi_byte(8'ha5);
        repeat (4) @(posedge clk);
        rd_chk(8'h12, 8'h01, 8'h01);
        chk({7'h0, irq}, 8'h00);
        rd_chk(8'h10, 8'hff, 8'ha5);
        rd_chk(8'h12, 8'h01, 8'h00);
        wr_reg(8'h14, 8'h04);
        sef_peer_i.spi_byte(8'h11);
        sef_peer_i.spi_byte(8'h22);
        repeat (4) @(posedge clk);
        rd_chk(8'h11, 8'hff, 8'h65);
        chk({7'h0, irq}, 8'h01);
        rd_chk(8'h10, 8'hff, 8'h11);
        wr_reg(8'h13, 8'h07);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({7'h0, irq}, 8'h00);
        wr_reg(8'h11, 8'h25);
        rd_chk(8'h11, 8'hff, 8'h25);
        $display("test spi slave done");
        // Buffer write in mid-transfer
        fork
            sef_peer_i.spi_byte(8'h5a);
            begin
                repeat (20) @(posedge clk);
                wr_reg(8'h10, 8'h99);
            end
        join
        repeat (4) @(posedge clk);
        rd_chk(8'h11, 8'hff, 8'ha5);
        rd_reg(8'h10, r);
        rd_chk(8'h11, 8'hff, 8'ha5);
        wr_reg(8'h11, 8'h25);
        // SPI slave with select control
        wr_reg(8'h11, 8'h24);
        sef_peer_i.spi_byte(8'h3c);
        repeat (4) @(posedge clk);
        rd_chk(8'h10, 8'hff, 8'h3c);
        $display("test collision done");
        // I2C master transmit: busy bus, then buffer-full timing
        @(posedge clk);
        tx <= 1'b1;
        wr_reg(8'h11, 8'h28);
        sef_peer_i.i2c_clk(8'hff, 0);
        wr_reg(8'h10, 8'hc3);
        rd_chk(8'h11, 8'hff, 8'ha8);
        wr_reg(8'h11, 8'h28);
        @(posedge clk);
        bus_idle <= 1'b1;
        wr_reg(8'h10, 8'hc3);
        rd_chk(8'h12, 8'h01, 8'h01);
        sef_peer_i.i2c_clk(8'hff, 8);
        chk(so, 8'hc3);
        repeat (4) @(posedge clk);
        rd_chk(8'h12, 8'h01, 8'h00);
        sef_peer_i.i2c_clk(8'hff, 1);
        rd_chk(8'h11, 8'hff, 8'h28);
        $display("test i2c master done");
        // I2C slave receive, second byte on an unread buffer
        @(posedge clk);
        tx <= 1'b0;
        wr_reg(8'h11, 8'h26);
        rd_reg(8'h10, r);
        sef_peer_i.i2c_clk(8'h96, 9);
        sef_peer_i.i2c_clk(8'h69, 9);
        rd_chk(8'h11, 8'hff, 8'h66);
        rd_chk(8'h10, 8'hff, 8'h96);
        sef_peer_i.i2c_idle();
        $display("test i2c slave done");
        finish_test();
    end
endmodule
